/* src/sfh_pkg.sv */
/*
  Shared constants and carrier types of the sector flash host sequencer.
  Assumes a 100 MHz system clock and an asynchronous byte-wide flash part on the pins.
*/
package sfh_pkg;
  localparam int CLK_NS       = 10;
  localparam int ADDR_W       = 19;
  localparam int DATA_W       = 8;
  localparam int SECT_BYTES   = 256;
  localparam int SECT_LSB     = 8;
  localparam int POLL_BIT     = 7;
  localparam int TOGGLE_BIT   = 6;
  localparam int SYNC_STAGES  = 2;
  localparam int CMD_WORDS    = 3;

  // Times in their own unit, cycle counts derived from them.
  localparam int T_ACC_NS      = 150;
  localparam int T_WE_PULSE_NS = 100;
  localparam int T_LOAD_GAP_NS = 150000;
  localparam int T_PROG_MS     = 20;
  localparam int T_PWRUP_MS    = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int ACC_CYC       = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_CYC        = (T_WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC        = ACC_CYC + SYNC_STAGES + 1;
  localparam int LOAD_GAP_DEF  = T_LOAD_GAP_NS / CLK_NS;
  localparam int PROG_DEF      = (T_PROG_MS * NS_PER_MS) / CLK_NS;
  localparam int PWRUP_DEF     = (T_PWRUP_MS * NS_PER_MS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_MARGIN   = 64;

  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 19'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR  = 19'h00001;

  typedef enum logic [1:0] {SFH_OP_READ, SFH_OP_PROG, SFH_OP_ID} sfh_op_t;
  typedef enum logic [1:0] {SFH_SEQ_PROG, SFH_SEQ_ID_IN, SFH_SEQ_ID_OUT} sfh_seq_t;

  typedef struct packed {
    sfh_op_t            op;
    logic [ADDR_W-1:0]  addr;
  } sfh_req_t;

  typedef struct packed {
    logic               err;
    logic [2*DATA_W-1:0] data;
  } sfh_rsp_t;

  typedef struct packed {
    logic               ce_n;
    logic               oe_n;
    logic               we_n;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  dq_out;
    logic               dq_oe;
  } sfh_pins_t;
endpackage

/* src/sfh_host.sv */
/*
  Host sequencer that reads, sector-programs and identifies an external byte-wide flash.
  Assumes the flash pins are wired straight to pins and dq_in is the resolved data bus level.
*/
`timescale 1ns/100ps
module sfh_host
  import sfh_pkg::*;
#(
  parameter int unsigned LOAD_GAP_CYC = LOAD_GAP_DEF,
  parameter int unsigned PROG_CYC     = PROG_DEF,
  parameter int unsigned PWRUP_CYC    = PWRUP_DEF,
  parameter logic [CMD_WORDS-1:0][ADDR_W-1:0] PROG_CMD_ADDR   = {19'h00003, 19'h00002, 19'h00001},
  parameter logic [CMD_WORDS-1:0][DATA_W-1:0] PROG_CMD_DATA   = {8'h03, 8'h02, 8'h01},
  parameter logic [CMD_WORDS-1:0][ADDR_W-1:0] IDIN_CMD_ADDR   = {19'h00006, 19'h00005, 19'h00004},
  parameter logic [CMD_WORDS-1:0][DATA_W-1:0] IDIN_CMD_DATA   = {8'h06, 8'h05, 8'h04},
  parameter logic [CMD_WORDS-1:0][ADDR_W-1:0] IDOUT_CMD_ADDR  = {19'h00009, 19'h00008, 19'h00007},
  parameter logic [CMD_WORDS-1:0][DATA_W-1:0] IDOUT_CMD_DATA  = {8'h09, 8'h08, 8'h07}
)(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              req_valid,
  input  wire sfh_req_t          req,
  output logic                   req_ready,
  input  wire logic              wr_valid,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic                   wr_ready,
  output logic                   rsp_valid,
  output sfh_rsp_t               rsp,
  output sfh_pins_t              pins,
  input  wire logic [DATA_W-1:0] dq_in
);
  localparam int TMR_W = $clog2(PROG_CYC + PWRUP_CYC + LOAD_GAP_CYC + 1);

  if (LOAD_GAP_CYC <= 2 * LOAD_MARGIN || PROG_CYC < 2 || PWRUP_CYC < 1)
  begin : g_bad
    $error("sfh_host: timing parameters too small");
  end

  typedef enum {B_IDLE, B_SETUP, B_STROBE, B_HOLD} sfh_bst_t;
  typedef enum {M_PWRUP, M_IDLE, M_READ, M_CMD, M_LOAD_WAIT, M_LOAD_WR, M_SETTLE,
                M_POLL, M_ID_RD, M_DONE} sfh_mst_t;

  // Selects one word of a command prefix; used for both address and data.
  function automatic logic [ADDR_W+DATA_W-1:0] cmd_word(sfh_seq_t s, logic [1:0] i);
    logic [ADDR_W+DATA_W-1:0] w;
    w = '0;
    case (s)
      SFH_SEQ_PROG:   w = {PROG_CMD_ADDR[i], PROG_CMD_DATA[i]};
      SFH_SEQ_ID_IN:  w = {IDIN_CMD_ADDR[i], IDIN_CMD_DATA[i]};
      SFH_SEQ_ID_OUT: w = {IDOUT_CMD_ADDR[i], IDOUT_CMD_DATA[i]};
      default:        w = '0;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------------------
  // Data input synchroniser
  // ----------------------------------------------------------------------------
  logic [DATA_W-1:0] dq_meta;
  logic [DATA_W-1:0] dq_sync;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dq_meta <= '0;
      dq_sync <= '0;
    end
    else
    begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------------------
  sfh_bst_t          bst;
  logic [7:0]        bcnt;
  logic              bus_go;
  logic              bus_wr;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_data;
  logic              bus_done;
  logic [DATA_W-1:0] bus_rdata;

  // Chip select falls first and rises last, so each strobe pulse sits inside it and
  // the address is settled a cycle before the falling strobe edge.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bst       <= B_IDLE;
      bcnt      <= '0;
      bus_done  <= 1'b0;
      bus_rdata <= '0;
      pins      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
    end
    else
    begin
      bus_done <= 1'b0;
      case (bst)
        B_IDLE:
          if (bus_go)
          begin
            pins.addr   <= bus_addr;
            pins.dq_out <= bus_data;
            pins.dq_oe  <= bus_wr;
            pins.ce_n   <= 1'b0;
            bst         <= B_SETUP;
          end
        B_SETUP:
        begin
          if (pins.dq_oe)
            pins.we_n <= 1'b0;
          else
            pins.oe_n <= 1'b0;
          bcnt <= '0;
          bst  <= B_STROBE;
        end
        B_STROBE:
        begin
          bcnt <= bcnt + 8'h01;
          if (bcnt == 8'((pins.dq_oe ? WE_CYC : RD_CYC) - 1))
          begin
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            if (!pins.dq_oe)
              bus_rdata <= dq_sync;
            bst <= B_HOLD;
          end
        end
        B_HOLD:
        begin
          pins.ce_n  <= 1'b1;
          pins.dq_oe <= 1'b0;
          bus_done   <= 1'b1;
          bst        <= B_IDLE;
        end
        default: bst <= B_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------------------
  sfh_mst_t          mst;
  sfh_seq_t          seq;
  logic [1:0]        cidx;
  logic              pend;
  logic              first_poll;
  logic [8:0]        byte_cnt;
  logic [ADDR_W-1:0] sect_addr;
  logic [DATA_W-1:0] last_data;
  logic [DATA_W-1:0] prev_rd;
  logic [TMR_W-1:0]  tmr;
  logic              err;
  logic              wr_take;

  assign wr_take = wr_valid && wr_ready;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mst <= M_PWRUP; seq <= SFH_SEQ_PROG; cidx <= '0; pend <= 1'b0; first_poll <= 1'b0;
      byte_cnt <= '0; sect_addr <= '0; last_data <= '0; prev_rd <= '0; tmr <= '0;
      err <= 1'b0; bus_go <= 1'b0; bus_wr <= 1'b0; bus_addr <= '0; bus_data <= '0;
      req_ready <= 1'b0; wr_ready <= 1'b0; rsp_valid <= 1'b0; rsp <= '0;
    end
    else
    begin
      bus_go    <= 1'b0;
      rsp_valid <= 1'b0;
      tmr       <= tmr + TMR_W'(1);
      if (bus_done)
        pend <= 1'b0;
      case (mst)
        M_PWRUP:
          if (tmr >= TMR_W'(PWRUP_CYC))
          begin
            mst       <= M_IDLE;
            req_ready <= 1'b1;
          end
        M_IDLE:
          if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            err       <= 1'b0;
            cidx      <= '0;
            sect_addr <= {req.addr[ADDR_W-1:SECT_LSB], SECT_LSB'(0)};
            bus_addr  <= req.addr;
            byte_cnt  <= '0;
            case (req.op)
              SFH_OP_PROG: begin seq <= SFH_SEQ_PROG; mst <= M_CMD; end
              SFH_OP_ID:   begin seq <= SFH_SEQ_ID_IN; mst <= M_CMD; end
              default:     begin bus_wr <= 1'b0; bus_go <= 1'b1; pend <= 1'b1; mst <= M_READ; end
            endcase
          end
        M_READ:
          if (bus_done)
          begin
            rsp <= '{err: 1'b0, data: {{DATA_W{1'b0}}, bus_rdata}};
            mst <= M_DONE;
          end
        M_CMD:
          if (!pend && !bus_done)
          begin
            {bus_addr, bus_data} <= cmd_word(seq, cidx);
            bus_wr <= 1'b1;
            bus_go <= 1'b1;
            pend   <= 1'b1;
          end
          else if (bus_done)
          begin
            cidx <= cidx + 2'd1;
            if (cidx == 2'(CMD_WORDS - 1))
            begin
              cidx <= '0;
              tmr  <= '0;
              case (seq)
                SFH_SEQ_PROG:  mst <= M_LOAD_WAIT;
                SFH_SEQ_ID_IN: mst <= M_ID_RD;
                default:       mst <= M_DONE;
              endcase
            end
          end
        M_LOAD_WAIT:
          // A stalled byte source is cut off short of the load window so the device never
          // programs a sector the host still believes it is loading.
          if (tmr >= TMR_W'(LOAD_GAP_CYC - LOAD_MARGIN))
          begin
            err      <= 1'b1;
            wr_ready <= 1'b0;
            mst      <= M_SETTLE;
          end
          else if (wr_take)
          begin
            wr_ready  <= 1'b0;
            bus_addr  <= {sect_addr[ADDR_W-1:SECT_LSB], byte_cnt[SECT_LSB-1:0]};
            bus_data  <= wr_data;
            last_data <= wr_data;
            bus_wr    <= 1'b1;
            bus_go    <= 1'b1;
            pend      <= 1'b1;
            mst       <= M_LOAD_WR;
          end
          else
            wr_ready <= 1'b1;
        M_LOAD_WR:
          if (bus_done)
          begin
            tmr      <= '0;
            byte_cnt <= byte_cnt + 9'd1;
            mst      <= (byte_cnt == 9'(SECT_BYTES - 1)) ? M_SETTLE : M_LOAD_WAIT;
          end
        M_SETTLE:
          // Reads are held off until the load window has surely closed.
          if (tmr >= TMR_W'(LOAD_GAP_CYC))
          begin
            tmr        <= '0;
            first_poll <= 1'b1;
            mst        <= M_POLL;
          end
        M_POLL:
          if (!pend && !bus_done)
          begin
            bus_wr <= 1'b0;
            bus_go <= 1'b1;
            pend   <= 1'b1;
          end
          else if (bus_done)
          begin
            prev_rd    <= bus_rdata;
            first_poll <= 1'b0;
            if (!first_poll && bus_rdata[TOGGLE_BIT] == prev_rd[TOGGLE_BIT]
                && bus_rdata[POLL_BIT] == last_data[POLL_BIT])
            begin
              rsp <= '{err: err, data: {{DATA_W{1'b0}}, bus_rdata}};
              mst <= M_DONE;
            end
            else if (tmr >= TMR_W'(PROG_CYC))
            begin
              rsp <= '{err: 1'b1, data: {{DATA_W{1'b0}}, bus_rdata}};
              mst <= M_DONE;
            end
          end
        M_ID_RD:
          if (!pend && !bus_done)
          begin
            bus_addr <= (cidx == 2'd0) ? ID_MAKER_ADDR : ID_PART_ADDR;
            bus_wr   <= 1'b0;
            bus_go   <= 1'b1;
            pend     <= 1'b1;
          end
          else if (bus_done)
          begin
            cidx <= cidx + 2'd1;
            if (cidx == 2'd0)
              rsp.data[2*DATA_W-1:DATA_W] <= bus_rdata;
            else
            begin
              rsp.data[DATA_W-1:0] <= bus_rdata;
              rsp.err              <= 1'b0;
              cidx                 <= '0;
              seq                  <= SFH_SEQ_ID_OUT;
              mst                  <= M_CMD;
            end
          end
        M_DONE:
        begin
          rsp_valid <= 1'b1;
          req_ready <= 1'b1;
          mst       <= M_IDLE;
        end
        default: mst <= M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_load_oe_high;
    @(posedge clk) disable iff (!resetn) !pins.we_n |-> pins.oe_n && !pins.ce_n;
  endproperty
  a_load_oe_high: assert property (p_load_oe_high) else $error("strobe low off select");

  property p_no_contention;
    @(posedge clk) disable iff (!resetn) pins.dq_oe |-> pins.oe_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("data driven on read");

  property p_we_width;
    @(posedge clk) disable iff (!resetn)
      $fell(pins.we_n) |-> !pins.we_n [*8] ##1 !pins.we_n ##1 !pins.we_n ##1 pins.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong");

  property p_load_gap;
    @(posedge clk) disable iff (!resetn)
      (mst == M_LOAD_WAIT) |-> tmr <= TMR_W'(LOAD_GAP_CYC - LOAD_MARGIN);
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("load gap too long");

  property p_sector_addr;
    @(posedge clk) disable iff (!resetn)
      $fell(pins.we_n) && mst == M_LOAD_WR
      |-> pins.addr[ADDR_W-1:SECT_LSB] == sect_addr[ADDR_W-1:SECT_LSB];
  endproperty
  a_sector_addr: assert property (p_sector_addr) else $error("sector address moved");

  property p_full_sector;
    @(posedge clk) disable iff (!resetn)
      $rose(mst == M_SETTLE) && !err |-> byte_cnt == 9'(SECT_BYTES);
  endproperty
  a_full_sector: assert property (p_full_sector) else $error("sector not fully loaded");

  property p_prefix_first;
    @(posedge clk) disable iff (!resetn)
      $fell(pins.we_n) && mst == M_CMD && seq == SFH_SEQ_PROG && cidx == 2'd0
      |-> pins.addr == PROG_CMD_ADDR[0] && pins.dq_out == PROG_CMD_DATA[0];
  endproperty
  a_prefix_first: assert property (p_prefix_first) else $error("prefix word wrong");

  property p_prefix_before_load;
    @(posedge clk) disable iff (!resetn)
      $rose(mst == M_LOAD_WAIT) && byte_cnt == 9'd0 |-> $past(mst) == M_CMD && seq == SFH_SEQ_PROG;
  endproperty
  a_prefix_before_load: assert property (p_prefix_before_load) else $error("load no prefix");
endmodule

/* dv/sfh_flash_model.sv */
/*
  Behavioural model of the byte-wide sector flash seen on the host's pins.
  Assumes time zero is power-up and the host keeps its default command prefix words.
*/
`timescale 1ns/100ps
module sfh_flash_model
  import sfh_pkg::*;
#(
  parameter int         LOAD_NS    = 3500,
  parameter int         PWRUP_NS   = 150,
  parameter int         GLITCH_NS  = 15,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] PART_CODE  = 8'ha7  // Arbitrary value.
)(
  input  wire sfh_pins_t         pins,
  input  wire logic [DATA_W-1:0] bus,
  input  wire logic signed [31:0] prog_ns,
  output logic [DATA_W-1:0]      dq,
  output logic                   dq_en
);
  logic [7:0]        mem [int];
  logic [7:0]        ld [int];
  logic [ADDR_W-1:0] wa;
  logic [7:0]        last = 8'h00;
  logic              wr_on = 1'b0, loading = 1'b0, busy = 1'b0, id_mode = 1'b0, tog = 1'b0;
  // The prefix state has no reset, so a supply dip cannot reopen programming.
  int                cmd_n = 0, kind = 0, sect = 0;
  realtime           t_fall, t_rise;

  // Prefix word i of kind k is k*3+i+1 in address and data alike.
  task automatic take(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    if (loading)
    begin
      if (ld.num() == 0)
        sect = int'(a[ADDR_W-1:SECT_LSB]);
      if (int'(a[ADDR_W-1:SECT_LSB]) == sect)
        ld[int'(a[SECT_LSB-1:0])] = d;
      last = d;
    end
    else if (!busy)
    begin
      if (cmd_n == 0)
        kind = (int'(a) - 1) / 3;
      if (a == 19'(d) && int'(a) == kind * 3 + cmd_n + 1 && kind < 3)
        cmd_n++;
      else
      begin
        cmd_n = 0;
        last = d;
        busy = 1'b1;
      end
      if (cmd_n == 3)
      begin
        cmd_n = 0;
        loading = (kind == 0);
        if (kind > 0)
          id_mode = (kind == 1);
      end
    end
  endtask

  always @(negedge pins.we_n or negedge pins.ce_n)
    if (!pins.ce_n && !pins.we_n && pins.oe_n)
    begin
      wa = pins.addr;
      t_fall = $realtime;
      wr_on = 1'b1;
    end

  always @(posedge pins.we_n or posedge pins.ce_n)
    if (wr_on)
    begin
      wr_on = 1'b0;
      t_rise = $realtime;
      if (t_rise - t_fall >= GLITCH_NS && t_rise >= PWRUP_NS)
        take(wa, bus);
    end

  always
  begin
    wait (loading);
    #10;
    if (!wr_on && $realtime - t_rise >= LOAD_NS)
    begin
      loading = 1'b0;
      busy = 1'b1;
      for (int j = 0; j < SECT_BYTES; j++)
        mem[sect * SECT_BYTES + j] = ld.exists(j) ? ld[j] : 8'hff;
      ld.delete();
    end
  end

  always
  begin
    wait (busy);
    #(prog_ns);
    busy = 1'b0;
  end

  always @(negedge pins.oe_n)
    if (busy && !pins.ce_n)
      tog = ~tog;

  initial dq = 8'h00;

  // A released bus shows the inverse of its last value, never a kind constant.
  always @(pins or busy or tog)
  begin
    dq_en = !pins.ce_n && !pins.oe_n && pins.we_n;
    if (!dq_en)
      dq = ~dq;
    else if (busy)
      dq = {~last[7], tog, last[5:0]};
    else if (id_mode && pins.addr <= 19'h00001)
      dq = pins.addr[0] ? PART_CODE : MAKER_CODE;
    else
      dq = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 8'hff;
  end
endmodule

/* dv/sector_flash_read_program_port_bench.sv */
/*
  Self-checking bench of the sector flash host sequencer against the flash model.
  Assumes the host's default prefix words and shortened timing parameters.
*/
`timescale 1ns/100ps
module sector_flash_read_program_port_bench
  import sfh_pkg::*;
;
  localparam int         PWRUP = 20;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value.
  localparam logic [7:0] PART  = 8'ha7; // Arbitrary value.
  logic              clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, wr_valid = 1'b0;
  logic              req_ready, wr_ready, rsp_valid, fl_en;
  logic [DATA_W-1:0] wr_data = 8'h00, dq_in, fl_dq;
  sfh_req_t          req = '0;
  sfh_rsp_t          rsp;
  sfh_pins_t         pins;
  int                prog_ns = 2000, n_mismatch = 0, num_checks = 0, cyc = 0;

  assign dq_in = pins.dq_oe ? pins.dq_out : fl_dq;

  sfh_host #(.LOAD_GAP_CYC(400), .PROG_CYC(2000), .PWRUP_CYC(PWRUP)) dut (
    .clk       (clk),
    .resetn    (resetn),
    .req_valid (req_valid),
    .req       (req),
    .req_ready (req_ready),
    .wr_valid  (wr_valid),
    .wr_data   (wr_data),
    .wr_ready  (wr_ready),
    .rsp_valid (rsp_valid),
    .rsp       (rsp),
    .pins      (pins),
    .dq_in     (dq_in)
  );

  sfh_flash_model #(.LOAD_NS(3500), .MAKER_CODE(MAKER), .PART_CODE(PART)) flash (
    .pins    (pins),
    .bus     (dq_in),
    .prog_ns (prog_ns),
    .dq      (fl_dq),
    .dq_en   (fl_en)
  );

  initial forever #5 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The cycle ceiling is about three times the expected run length.
  always @(negedge clk)
  begin
    cyc <= cyc + 1;
    if (fl_en)
      check(pins.dq_oe, 1'b0);
    if (cyc == 90000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  function automatic logic [7:0] pat(input int s, input int i);
    return 8'(i * 7 + s);
  endfunction

  task automatic issue(input sfh_op_t op, input logic [ADDR_W-1:0] a);
    int n = 0;
    req.op = op;
    req.addr = a;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n++ < 100) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic wait_rsp();
    int n = 0;
    while (rsp_valid !== 1'b1 && n++ < 20000) @(negedge clk);
    check(rsp_valid, 1'b1);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    issue(SFH_OP_READ, a);
    wait_rsp();
    check(rsp, {9'h000, exp});
  endtask

  // Offers nb bytes back to back; fewer than a sector makes the host give up.
  task automatic prog(input int sect, seed, nb, ns, input logic err);
    int n;
    prog_ns = ns;
    issue(SFH_OP_PROG, 19'(sect) << SECT_LSB);
    wr_valid = 1'b1;
    for (int i = 0; i < nb; i++)
    begin
      wr_data = pat(seed, i);
      n = 0;
      while (wr_ready !== 1'b1 && n++ < 200) @(negedge clk);
      @(negedge clk);
    end
    check(wr_ready, 1'b0);
    wr_valid = 1'b0;
    wait_rsp();
    check(rsp.err, err);
  endtask

  task automatic t_reset();
    repeat (10) @(negedge clk);
    check({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, req_ready, rsp_valid}, 6'h38);
    resetn = 1'b1;
    repeat (PWRUP - 2) @(negedge clk);
    check(req_ready, 1'b0);
    repeat (6) @(negedge clk);
    check(req_ready, 1'b1);
  endtask

  task automatic t_full();
    prog(5, 5, 256, 2000, 1'b0);
    check(rsp.data[7:0], pat(5, 255));
    for (int i = 0; i < 256; i++)
      rd_chk(19'(5 * 256 + i), pat(5, i));
  endtask

  // A short reload of a filled sector must erase the old bytes it skips.
  task automatic t_erase();
    prog(5, 9, 10, 15000, 1'b1);
    repeat (2000) @(negedge clk);
    rd_chk(19'h00509, pat(9, 9));
    rd_chk(19'h0050a, 8'hff);
  endtask

  task automatic t_slow_top();
    prog(2047, 3, 256, 15000, 1'b0);
    rd_chk(19'h7ffff, pat(3, 255));
    rd_chk(19'h7ff00, pat(3, 0));
  endtask

  task automatic t_timeout();
    prog(1, 1, 256, 40000, 1'b1);
    repeat (3000) @(negedge clk);
    rd_chk(19'h00100, pat(1, 0));
  endtask

  task automatic t_ident();
    issue(SFH_OP_ID, 19'h00000);
    wait_rsp();
    check(rsp, {1'b0, MAKER, PART});
    rd_chk(19'h00000, 8'hff);
  endtask

  initial
  begin
    t_reset();
    rd_chk(19'h12345, 8'hff);
    t_full();
    t_erase();
    t_slow_top();
    t_timeout();
    t_ident();
    close_out();
  end
endmodule
